/* File: verilog/qec_counter.v */
// Incremental encoder position counter with index capture, reached over AXI4-Lite.
// What this block does
// [R1] Position is a 32-bit signed value that software reads and overwrites.
// [R2] Each encoder count adds or subtracts a signed 16.16 increment constant.
// [R3] Decimal select 0 scales the fraction by 65536, 1 scales it by 10000.
// [R4] Software picks the constant's sign to match the motor's rotation direction.
// [R5] After reset the increment constant is 1.0, raw value 65536.
// [R6] Index event sets flag bit 0; reading the flags register clears it.
// [R7] The index flag drives the interrupt output while set.
// [R8] A qualifying index event copies the position into the capture register.
// [R9] Config write with bit 11 set captures at once; zero does nothing.
// [R10] Config bit 9 also captures the ramp position with index and capture-now captures, not with switch captures.
// [R11] Config bit 8 zero only captures; one captures and then clears position.
// [R12] Bits 7:6 pick level, active edge, inactive edge or both edges.
// [R13] Config bit 5 acts only on the first index event after the write.
// [R14] Config bit 4 acts on every index event.
// [R15] Bit 3 zero needs N, A and B at their polarities; one ignores A, B.
// [R16] Config bit 2 gives the index active level, 1 meaning high active.
// [R17] Config bits 1 and 0 give the required B and A levels.
// [R18] Switch-event capture option also captures encoder position on a switch event.
// [R19] A/B transitions count forward or backward; double transitions are ignored.
// [R20] An index event in the same cycle as a flags read keeps the flag set.
`timescale 1ns/1ps
`include "qec_consts.vh"

module qec_counter #(
	parameter ADDR_W = `QEC_ADDR_W,
	parameter [31:0] CONST_RESET = `QEC_CONST_RESET
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire enc_a,
	input wire enc_b,
	input wire enc_n,
	input wire [31:0] ramp_actual_position,
	input wire ref_switch_event,
	output reg [31:0] ramp_capture_r,
	output reg ramp_capture_strobe_r,
	output wire irq
);

	wire wr_en;
	wire rd_en;
	wire [`QEC_IDX_W-1:0] wr_idx;
	wire [`QEC_IDX_W-1:0] rd_idx;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	reg [31:0] rd_data;
	reg rd_err;
	reg wr_err;

	qec_axil #(
		.ADDR_W(ADDR_W)
	) u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data_r(wr_data),
		.wr_strb_r(wr_strb),
		.wr_err(wr_err),
		.rd_en(rd_en),
		.rd_idx(rd_idx),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// Byte-lane merge of a write into a stored word.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	reg [`QEC_CFG_W-1:0] config_r;
	reg [31:0] position_r;
	reg [17:0] frac_r;
	reg [31:0] const_r;
	reg flag_r;
	reg [31:0] capture_r;
	reg aux_r;
	reg once_pend_r;
	reg qual_prev_r;

	reg [2:0] a_sync_r;
	reg [2:0] b_sync_r;
	reg [1:0] n_sync_r;

	// Two-stage synchronisers; the third A/B stage aligns the phases with the decoder output.
	always @(posedge aclk) begin
		if (!aresetn) begin
			a_sync_r <= 3'b000;
			b_sync_r <= 3'b000;
			n_sync_r <= 2'b00;
		end else begin
			a_sync_r <= {a_sync_r[1:0], enc_a};
			b_sync_r <= {b_sync_r[1:0], enc_b};
			n_sync_r <= {n_sync_r[0], enc_n};
		end
	end

	wire count;
	wire count_up;

	// The decoder sees only the second synchroniser stage, never the first.
	qec_quad u_quad (
		.aclk(aclk),
		.aresetn(aresetn),
		.phase_a(a_sync_r[1]),
		.phase_b(b_sync_r[1]),
		.count_r(count),
		.count_up_r(count_up)
	);

	wire wr_config;
	wire wr_position;
	wire wr_const;
	wire wr_aux;
	wire rd_flags;
	wire [31:0] config_wdata;
	wire [31:0] aux_wdata;

	assign wr_config = wr_en && (wr_idx == `QEC_IDX_CONFIG);
	assign wr_position = wr_en && (wr_idx == `QEC_IDX_POSITION);
	assign wr_const = wr_en && (wr_idx == `QEC_IDX_CONST);
	assign wr_aux = wr_en && (wr_idx == `QEC_IDX_AUX_CONFIG);
	assign rd_flags = rd_en && (rd_idx == `QEC_IDX_FLAGS);
	assign config_wdata = merge({{(32-`QEC_CFG_W){1'b0}}, config_r}, wr_data, wr_strb);
	assign aux_wdata = merge({31'h0000_0000, aux_r}, wr_data, wr_strb);

	// Index qualification on the synchronised N level and the phase levels.
	// With the reset configuration an idle encoder at A=B=0 with N low already qualifies,
	// so level sensitivity keeps raising the flag until software reconfigures.
	wire n_active;
	wire phase_match;
	wire qual_level;
	reg index_event;

	assign n_active = (n_sync_r[1] == config_r[`QEC_CFG_POL_N]); // [R16]
	assign phase_match = (a_sync_r[2] == config_r[`QEC_CFG_POL_A]) && // [R17]
		(b_sync_r[2] == config_r[`QEC_CFG_POL_B]);
	assign qual_level = n_active && (config_r[`QEC_CFG_PHASE_GATE_OFF] || phase_match); // [R15]

	always @* begin
		case (config_r[`QEC_CFG_SENS_HI:`QEC_CFG_SENS_LO]) // [R12]
		`QEC_SENS_LEVEL: index_event = qual_level;
		`QEC_SENS_ACTIVE_EDGE: index_event = qual_level && !qual_prev_r;
		`QEC_SENS_INACTIVE_EDGE: index_event = !qual_level && qual_prev_r;
		`QEC_SENS_BOTH_EDGES: index_event = qual_level ^ qual_prev_r;
		default: index_event = 1'b0;
		endcase
	end

	wire index_action;
	wire capture_now;
	wire switch_capture;
	wire do_capture;
	wire ramp_take;
	wire clear_position;

	assign index_action = index_event && // [R13] [R14]
		(config_r[`QEC_CFG_CONTINUOUS] || once_pend_r);
	// Capture now needs the byte lane that carries bit 11; a zero there does nothing.
	assign capture_now = wr_config && wr_strb[1] && wr_data[`QEC_CFG_CAPTURE_NOW]; // [R9]
	// The switch event is the ramp block's own capture pulse, one cycle long.
	assign switch_capture = ref_switch_event && aux_r; // [R18]
	assign do_capture = index_action || capture_now || switch_capture;
	assign ramp_take = (index_action && config_r[`QEC_CFG_RAMP_CAPTURE]) || // [R10]
		(capture_now && config_wdata[`QEC_CFG_RAMP_CAPTURE]);
	assign clear_position = index_action && config_r[`QEC_CFG_CLEAR_ON_INDEX]; // [R11]

	// Fractional accumulation modulo 65536 or 10000, carrying into the integer position.
	wire [17:0] modulus;
	wire [15:0] step_int;
	wire [17:0] step_frac;
	wire [17:0] frac_sum;
	wire frac_carry;
	wire frac_borrow;
	reg [17:0] frac_next;
	reg [31:0] pos_delta;

	assign modulus = config_r[`QEC_CFG_DECIMAL] ? `QEC_MOD_DECIMAL : `QEC_MOD_BINARY; // [R3]
	assign step_int = const_r[31:16];
	assign step_frac = {2'b00, const_r[15:0]};
	assign frac_sum = frac_r + step_frac;
	assign frac_carry = frac_sum >= modulus;
	assign frac_borrow = frac_r < step_frac;

	always @* begin
		if (count_up) begin
			frac_next = frac_carry ? frac_sum - modulus : frac_sum;
			pos_delta = {{16{step_int[15]}}, step_int} + {31'h0000_0000, frac_carry}; // [R2]
		end else begin
			// A fraction underflow borrows one more unit from the integer step.
			frac_next = frac_borrow ? frac_r + modulus - step_frac : frac_r - step_frac;
			pos_delta = ~({{16{step_int[15]}}, step_int} + {31'h0000_0000, frac_borrow}) +
				32'h0000_0001; // [R2]
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			config_r <= `QEC_CFG_RESET;
			position_r <= 32'h0000_0000;
			frac_r <= 18'h00000;
			const_r <= CONST_RESET; // [R5]
			aux_r <= 1'b0;
			once_pend_r <= 1'b0;
			qual_prev_r <= 1'b0;
		end else begin
			qual_prev_r <= qual_level;
			if (wr_config) begin
				config_r <= config_wdata[`QEC_CFG_W-1:0];
			end
			if (wr_const) begin
				const_r <= merge(const_r, wr_data, wr_strb);
			end
			if (wr_aux) begin
				aux_r <= aux_wdata[`QEC_AUX_SWITCH_CAPTURE];
			end
			// A config write arms or disarms single-shot mode; any detected event consumes it.
			if (wr_config) begin
				once_pend_r <= config_wdata[`QEC_CFG_ONCE]; // [R13]
			end else if (index_event) begin
				once_pend_r <= 1'b0; // [R13]
			end
			// A software write beats an index clear, which beats a count in the same cycle.
			if (wr_position) begin
				position_r <= merge(position_r, wr_data, wr_strb); // [R1]
				frac_r <= 18'h00000;
			end else if (clear_position) begin
				position_r <= 32'h0000_0000; // [R11]
				frac_r <= 18'h00000;
			end else if (count) begin
				position_r <= position_r + pos_delta; // [R2] [R19]
				frac_r <= frac_next;
			end
		end
	end

	// Captures always take the position held before this cycle's update.
	always @(posedge aclk) begin
		if (!aresetn) begin
			capture_r <= 32'h0000_0000;
			ramp_capture_r <= 32'h0000_0000;
			ramp_capture_strobe_r <= 1'b0;
		end else begin
			ramp_capture_strobe_r <= ramp_take;
			if (do_capture) begin
				capture_r <= position_r; // [R8] [R9] [R18]
			end
			if (ramp_take) begin
				ramp_capture_r <= ramp_actual_position; // [R10]
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			flag_r <= 1'b0;
		end else if (index_event) begin
			// Setting wins over the read clear so that no index event is lost.
			flag_r <= 1'b1; // [R6] [R20]
		end else if (rd_flags) begin
			flag_r <= 1'b0; // [R6]
		end
	end

	assign irq = flag_r; // [R7]

	always @* begin
		rd_err = 1'b0;
		case (rd_idx)
		`QEC_IDX_CONFIG: rd_data = {{(32-`QEC_CFG_W){1'b0}}, config_r};
		`QEC_IDX_POSITION: rd_data = position_r; // [R1]
		// The increment constant is write only and reads back as zero.
		`QEC_IDX_CONST: rd_data = 32'h0000_0000;
		`QEC_IDX_FLAGS: rd_data = {31'h0000_0000, flag_r};
		`QEC_IDX_CAPTURE: rd_data = capture_r;
		`QEC_IDX_RAMP_CAPTURE: rd_data = ramp_capture_r;
		`QEC_IDX_AUX_CONFIG: rd_data = {31'h0000_0000, aux_r};
		default: begin
			rd_data = 32'h0000_0000;
			rd_err = 1'b1;
		end
		endcase
	end

	// Writes to read-only registers are accepted and ignored; unmapped indices get an error.
	always @* begin
		case (wr_idx)
		`QEC_IDX_CONFIG: wr_err = 1'b0;
		`QEC_IDX_POSITION: wr_err = 1'b0;
		`QEC_IDX_CONST: wr_err = 1'b0;
		`QEC_IDX_AUX_CONFIG: wr_err = 1'b0;
		`QEC_IDX_FLAGS: wr_err = 1'b0;
		`QEC_IDX_CAPTURE: wr_err = 1'b0;
		`QEC_IDX_RAMP_CAPTURE: wr_err = 1'b0;
		default: wr_err = 1'b1;
		endcase
	end

endmodule // qec_counter

/* File: verilog/qec_consts.vh */
// Register indices, field positions, reset values and scaling constants of the encoder counter.
`ifndef QEC_CONSTS_VH
`define QEC_CONSTS_VH

`define QEC_ADDR_W 8
`define QEC_IDX_W 6

`define QEC_IDX_CONFIG 6'h38
`define QEC_IDX_POSITION 6'h39
`define QEC_IDX_CONST 6'h3a
`define QEC_IDX_FLAGS 6'h3b
`define QEC_IDX_CAPTURE 6'h3c
`define QEC_IDX_RAMP_CAPTURE 6'h3d
`define QEC_IDX_AUX_CONFIG 6'h3e

`define QEC_CFG_W 12
`define QEC_CFG_CAPTURE_NOW 11
`define QEC_CFG_DECIMAL 10
`define QEC_CFG_RAMP_CAPTURE 9
`define QEC_CFG_CLEAR_ON_INDEX 8
`define QEC_CFG_SENS_HI 7
`define QEC_CFG_SENS_LO 6
`define QEC_CFG_ONCE 5
`define QEC_CFG_CONTINUOUS 4
`define QEC_CFG_PHASE_GATE_OFF 3
`define QEC_CFG_POL_N 2
`define QEC_CFG_POL_B 1
`define QEC_CFG_POL_A 0
`define QEC_CFG_RESET 12'h000

`define QEC_SENS_LEVEL 2'b00
`define QEC_SENS_ACTIVE_EDGE 2'b01
`define QEC_SENS_INACTIVE_EDGE 2'b10
`define QEC_SENS_BOTH_EDGES 2'b11

`define QEC_AUX_SWITCH_CAPTURE 0
`define QEC_FLAG_INDEX 0

`define QEC_CONST_RESET 32'h0001_0000
`define QEC_MOD_BINARY 18'h10000
`define QEC_MOD_DECIMAL 18'h02710

`define QEC_RESP_OKAY 2'b00
`define QEC_RESP_SLVERR 2'b10

`endif

/* File: verilog/qec_quad.v */
// Quadrature A/B decoder giving one count pulse and its direction per valid transition.
`timescale 1ns/1ps
`include "qec_consts.vh"

module qec_quad (
	input wire aclk,
	input wire aresetn,
	input wire phase_a,
	input wire phase_b,
	output reg count_r,
	output reg count_up_r
);

	reg prev_a_r;
	reg prev_b_r;
	wire change_a;
	wire change_b;

	assign change_a = phase_a ^ prev_a_r;
	assign change_b = phase_b ^ prev_b_r;

	// Forward order of {A,B} is 00, 10, 11, 01; a double change is discarded.
	always @(posedge aclk) begin
		if (!aresetn) begin
			prev_a_r <= 1'b0;
			prev_b_r <= 1'b0;
			count_r <= 1'b0;
			count_up_r <= 1'b0;
		end else begin
			prev_a_r <= phase_a;
			prev_b_r <= phase_b;
			count_r <= change_a ^ change_b; // [R19]
			count_up_r <= ~(prev_a_r ^ phase_b); // [R19]
		end
	end

endmodule // qec_quad

/* File: verilog/qec_axil.v */
// AXI4-Lite slave front end turning bus transfers into one-cycle register strobes.
`timescale 1ns/1ps
`include "qec_consts.vh"

module qec_axil #(
	parameter ADDR_W = `QEC_ADDR_W
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire wr_en,
	output wire [`QEC_IDX_W-1:0] wr_idx,
	output reg [31:0] wr_data_r,
	output reg [3:0] wr_strb_r,
	input wire wr_err,
	output wire rd_en,
	output wire [`QEC_IDX_W-1:0] rd_idx,
	input wire [31:0] rd_data,
	input wire rd_err
);

	reg aw_hold_r;
	reg w_hold_r;
	reg ar_hold_r;
	reg [ADDR_W-1:0] awaddr_r;
	reg [ADDR_W-1:0] araddr_r;

	assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
	assign s_axi_arready = !ar_hold_r && !s_axi_rvalid;
	assign wr_en = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign rd_en = ar_hold_r && !s_axi_rvalid;
	assign wr_idx = awaddr_r[`QEC_IDX_W+1:2];
	assign rd_idx = araddr_r[`QEC_IDX_W+1:2];

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			ar_hold_r <= 1'b0;
			awaddr_r <= {ADDR_W{1'b0}};
			araddr_r <= {ADDR_W{1'b0}};
			wr_data_r <= 32'h0000_0000;
			wr_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `QEC_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `QEC_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wr_data_r <= s_axi_wdata;
				wr_strb_r <= s_axi_wstrb;
			end
			if (wr_en) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err ? `QEC_RESP_SLVERR : `QEC_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				ar_hold_r <= 1'b1;
				araddr_r <= s_axi_araddr;
			end
			if (rd_en) begin
				ar_hold_r <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_err ? 32'h0000_0000 : rd_data;
				s_axi_rresp <= rd_err ? `QEC_RESP_SLVERR : `QEC_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // qec_axil

/* File: verif/qec_counter_props.sv */
// Concurrent checks on the encoder counter's ports.
`timescale 1ns/1ps
module qec_counter_props (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] ramp_capture_r,
	input wire ramp_capture_strobe_r,
	input wire irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	irq_reset_a: assert property ($rose(aresetn) |-> !irq)
		else $error("irq high after reset");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	write_resp_a: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response late");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready
		|=> !s_axi_rvalid ##1 s_axi_rvalid) else $error("read data late");
	bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid kept after handshake");
	irq_clear_a: assert property ($fell(irq)
		|-> $past(s_axi_arvalid && s_axi_arready, 2)) else $error("irq fell without read");
	ramp_load_a: assert property ($changed(ramp_capture_r)
		|-> ramp_capture_strobe_r) else $error("ramp capture without strobe");
	irq_c: cover property ($rose(irq));
	ramp_c: cover property (ramp_capture_strobe_r);
	read_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule // qec_counter_props

bind qec_counter qec_counter_props u_props (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.ramp_capture_r, .ramp_capture_strobe_r, .irq);

/* File: verif/qec_enc_model.sv */
// Quadrature encoder model driving phases A, B and index N.
`timescale 1ns/1ps
module qec_enc_model (
	input wire aclk,
	output wire enc_a,
	output wire enc_b,
	output reg enc_n
);
	reg [1:0] ph;
	// Phase count 0..3 maps to {A,B} = 00, 10, 11, 01.
	assign enc_a = ph[1] ^ ph[0];
	assign enc_b = ph[1];
	initial begin
		ph = 2'd0;
		enc_n = 1'b0;
	end
	task step(input fwd, input dbl);
		begin
			@(posedge aclk);
			if (dbl)
				ph <= ph + 2'd2;
			else
				ph <= fwd ? ph + 2'd1 : ph - 2'd1;
			repeat (6) @(posedge aclk);
		end
	endtask
	task nset(input v);
		begin
			@(posedge aclk);
			enc_n <= v;
			repeat (6) @(posedge aclk);
		end
	endtask
endmodule // qec_enc_model

/* File: verif/tb_top.sv */
// Self-checking bench for the encoder counter.
`timescale 1ns/1ps
`include "qec_consts.vh"
module tb_top;
	localparam [5:0] CF = `QEC_IDX_CONFIG;
	localparam [5:0] PS = `QEC_IDX_POSITION;
	localparam [5:0] KC = `QEC_IDX_CONST;
	localparam [5:0] FL = `QEC_IDX_FLAGS;
	localparam [5:0] CP = `QEC_IDX_CAPTURE;
	reg aclk, aresetn, awv, wv, bry, arv, rry, sw;
	reg [7:0] awa, ara;
	reg [31:0] wd, ramp, v;
	reg [1:0] r;
	wire awr, wr, bv, arr, rv, ea, eb, en, irq;
	wire [1:0] br, rr;
	wire [31:0] rd, rcap;
	integer error_cnt, cmp_count, cyc, i;
	qec_counter uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .enc_a(ea), .enc_b(eb), .enc_n(en),
		.ramp_actual_position(ramp), .ref_switch_event(sw),
		.ramp_capture_r(rcap), .ramp_capture_strobe_r(), .irq(irq));
	qec_enc_model em (.aclk(aclk), .enc_a(ea), .enc_b(eb), .enc_n(en));
	task chk(input [31:0] s, input [31:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (s !== e) begin
				error_cnt = error_cnt + 1;
				$display("BAD %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task finish_test;
		begin
			if (error_cnt == 0 && cmp_count > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task wrr(input [5:0] x, input [31:0] d);
		reg a, w;
		begin
			@(posedge aclk);
			awa <= {x, 2'b00};
			wd <= d;
			awv <= 1'b1;
			wv <= 1'b1;
			bry <= 1'b1;
			a = 1'b0;
			w = 1'b0;
			while (!(a && w)) begin
				@(posedge aclk);
				if (!a && awr) begin
					a = 1'b1;
					awv <= 1'b0;
				end
				if (!w && wr) begin
					w = 1'b1;
					wv <= 1'b0;
				end
			end
			while (bv !== 1'b1) @(posedge aclk);
			r = br;
			bry <= 1'b0;
		end
	endtask
	task rc(input [5:0] x, input [31:0] e);
		reg a;
		begin
			@(posedge aclk);
			ara <= {x, 2'b00};
			arv <= 1'b1;
			rry <= 1'b1;
			a = 1'b0;
			while (!a) begin
				@(posedge aclk);
				if (arr === 1'b1) begin
					a = 1'b1;
					arv <= 1'b0;
				end
			end
			while (rv !== 1'b1) @(posedge aclk);
			v = rd;
			r = rr;
			rry <= 1'b0;
			chk(v, e);
		end
	endtask
	task pulse;
		begin
			em.nset(1'b1);
			em.nset(1'b0);
		end
	endtask
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt = error_cnt + 1;
			finish_test;
		end
	end
	initial begin
		{awv, wv, bry, arv, rry, sw} = 6'h00;
		{awa, ara} = 16'h0000;
		wd = 32'h0;
		ramp = 32'h1234_5678;
		aresetn = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// The reset config is level sensitive and low active, so the idle encoder flags at once.
		for (i = 0; i < 5; i = i + 1)
			rc(CF + i, (CF + i == FL) ? 32'h1 : 32'h0);
		rc(6'h3f, 32'h0);
		chk(r, `QEC_RESP_SLVERR);
		for (i = 0; i < 4; i = i + 1)
			em.step(1'b1, 1'b0);
		rc(PS, 32'h4);
		em.step(1'b0, 1'b0);
		em.step(1'b1, 1'b1);
		rc(PS, 32'h3);
		wrr(KC, 32'h0002_8000);
		em.step(1'b1, 1'b0);
		em.step(1'b1, 1'b0);
		rc(PS, 32'h8);
		wrr(CF, 32'h400);
		wrr(KC, 32'h0000_1388);
		em.step(1'b1, 1'b0);
		em.step(1'b1, 1'b0);
		rc(PS, 32'h9);
		wrr(CF, 32'h0);
		wrr(KC, 32'hffff_0000);
		em.step(1'b1, 1'b0);
		rc(PS, 32'h8);
		wrr(PS, 32'h8000_0000);
		rc(PS, 32'h8000_0000);
		wrr(CF, 32'ha00);
		rc(CP, 32'h8000_0000);
		chk(rcap, 32'h1234_5678);
		wrr(PS, 32'h5);
		wrr(CF, 32'h200);
		wrr(CP, 32'h1);
		rc(CP, 32'h8000_0000);
		rc(FL, 32'h1);
		chk(irq, 1'b0);
		wrr(CF, 32'h157);
		pulse;
		chk(irq, 1'b1);
		rc(CP, 32'h5);
		rc(PS, 32'h0);
		rc(FL, 32'h1);
		rc(FL, 32'h0);
		chk(irq, 1'b0);
		wrr(CF, 32'h154);
		pulse;
		rc(FL, 32'h0);
		wrr(CF, 32'h15c);
		pulse;
		rc(FL, 32'h1);
		for (i = 0; i < 4; i = i + 1) begin
			wrr(CF, 32'hc | (i << 6));
			em.nset(1'b1);
			rc(FL, i != 2);
			em.nset(1'b0);
			rc(FL, i != 1);
			rc(FL, 32'h0);
		end
		wrr(PS, 32'h50);
		wrr(CF, 32'h6c);
		pulse;
		wrr(PS, 32'h60);
		pulse;
		rc(CP, 32'h50);
		rc(PS, 32'h60);
		ramp <= 32'h2468_ace0;
		wrr(CF, 32'h25c);
		pulse;
		rc(CP, 32'h60);
		chk(rcap, 32'h2468_ace0);
		wrr(PS, 32'h70);
		pulse;
		rc(CP, 32'h70);
		wrr(`QEC_IDX_AUX_CONFIG, 32'h1);
		wrr(PS, 32'h77);
		@(posedge aclk);
		sw <= 1'b1;
		@(posedge aclk);
		sw <= 1'b0;
		rc(CP, 32'h77);
		finish_test;
	end
endmodule // tb_top
